// ==== core/tcc_pkg.sv ====
// Constants and types shared by the timer capture/compare block.
package tcc_pkg;

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [15:0] ADDR_TIMER_MODE_CONTROL = 16'hFF60;
	localparam logic [15:0] ADDR_CAPTURE_COMPARE_CONTROL = 16'hFF62;
	localparam logic [15:0] ADDR_UP_COUNTER = 16'hFF10;
	localparam logic [15:0] ADDR_CC_REG_A = 16'hFF12;
	localparam logic [15:0] ADDR_CC_REG_B = 16'hFF14;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int MODE_SEL_LO_POS = 2;
	localparam int OVERFLOW_FLAG_POS = 0;
	localparam int REG_A_CAPTURE_SEL_POS = 0;
	localparam int REG_A_TRIGGER_SEL_POS = 1;
	localparam int REG_B_CAPTURE_SEL_POS = 2;
	localparam int INPUT_A_EDGE_LO_POS = 4;
	localparam int INPUT_B_EDGE_LO_POS = 6;
	localparam logic [7:0] TIMER_MODE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] CAPTURE_COMPARE_CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_STEP = 16'h0001;

	// ************************************************************
	// Modes and edge codes
	// ************************************************************
	typedef enum logic [1:0] {
		TCC_STOP = 2'h0,
		TCC_FREE_RUN = 2'h1,
		TCC_CLEAR_ON_EDGE = 2'h2,
		TCC_CLEAR_ON_MATCH_A = 2'h3
	} tcc_mode_e;

	localparam logic [1:0] EDGE_FALLING = 2'h0;
	localparam logic [1:0] EDGE_RISING = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage

// ==== core/tcc_edge.sv ====
// Pin synchroniser and edge detector for one trigger input.
`timescale 1ns/1ps
module tcc_edge
	import tcc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic pin,
	output logic rise,
	output logic fall
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
		logic rise;
		logic fall;
	} tcc_edge_s;

	tcc_edge_s st;
	tcc_edge_s next_st;

	// The first stage feeds only the second; the detector looks at sync2 and last.
	always_comb begin
		next_st = st;
		next_st.sync1 = pin;
		next_st.sync2 = st.sync1;
		next_st.last = st.sync2;
		next_st.rise = st.sync2 & ~st.last;
		next_st.fall = ~st.sync2 & st.last;
	end

	// A pin held high through reset shows as a rising edge once released.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign rise = st.rise;
	assign fall = st.fall;

endmodule

// ==== core/tcc_core.sv ====
// 16-bit timer counter with two capture/compare registers and mode control.
//
// Functional notes
// - Free-run or edge-clear mode: compare value 0000H matches right after wrap.
// - Compare A below count: counter runs on, wraps, then can match.
// - Control bit 2 makes register B compare (0) or capture (1).
// - Register B as compare is checked every tick; equality raises match B.
// - Register B captures on input A valid edge; code 10 gives no edge.
// - Registers A and B take whole 16-bit writes; no reset value.
// - Mode field: stop and clear, free run, clear on edge A, clear on match A.
// - Counter runs while mode is nonzero and stops when 00 is written.
// - Free-run and match-A modes toggle output and interrupt on A or B match.
// - Mode control bit 0 reads 1 once counter overflow was seen.
// - Match-A mode with A at FFFFH sets overflow on FFFFH to 0000H.
// - Control bit 1 picks A's trigger: edge B, or edge A opposite phase.
// - Control bit 0 makes register A compare (0) or capture (1).
// - Both control registers reset to 00H and accept byte-wide writes.
// - Read-only counter steps per count tick; a read defers the tick.
// - Edge fields: 00 falling, 01 rising, 11 both, 10 no edge.
`timescale 1ns/1ps
module tcc_core
	import tcc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic count_tick,
	input wire logic [7:0] prescaler_mode_reg,
	input wire logic edge_input_a,
	input wire logic edge_input_b,
	input wire logic [15:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_word,
	input wire logic bus_rd,
	output logic [15:0] bus_rdata,
	output logic match_irq_a,
	output logic match_irq_b,
	output logic timer_output
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [15:0] up_counter;
		logic [15:0] cc_reg_a;
		logic [15:0] cc_reg_b;
		tcc_mode_e mode;
		logic overflow_flag;
		logic reg_b_capture_sel;
		logic reg_a_trigger_sel;
		logic reg_a_capture_sel;
		logic tick_pending;
		logic irq_a;
		logic irq_b;
		logic tout;
		logic [15:0] rdata;
	} tcc_core_s;

	tcc_core_s st;
	tcc_core_s next_st;

	logic rise_a;
	logic fall_a;
	logic rise_b;
	logic fall_b;
	logic [1:0] input_a_edge;
	logic [1:0] input_b_edge;
	logic running;
	logic counter_read;
	logic tick_now;
	logic edge_a_valid;
	logic edge_b_valid;
	logic trig_a;
	logic match_a;
	logic match_b;

	// ************************************************************
	// Edge helpers
	// ************************************************************
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		logic hit;
		hit = 1'b0;
		unique case (sel)
			EDGE_FALLING: hit = f;
			EDGE_RISING: hit = r;
			EDGE_BOTH: hit = r | f;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic logic edge_opposite(input logic [1:0] sel, input logic r, input logic f);
		logic hit;
		hit = 1'b0;
		unique case (sel)
			EDGE_FALLING: hit = r;
			EDGE_RISING: hit = f;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	tcc_edge u_edge_a (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.pin(edge_input_a),
		.rise(rise_a),
		.fall(fall_a)
	);

	tcc_edge u_edge_b (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.pin(edge_input_b),
		.rise(rise_b),
		.fall(fall_b)
	);

	// ************************************************************
	// Event decode
	// ************************************************************
	always_comb begin
		input_a_edge = prescaler_mode_reg[INPUT_A_EDGE_LO_POS +: 2];
		input_b_edge = prescaler_mode_reg[INPUT_B_EDGE_LO_POS +: 2];
		running = (st.mode != TCC_STOP);
		counter_read = bus_rd && (bus_addr == ADDR_UP_COUNTER);
		// A tick that lands on a counter read waits one cycle so the read is coherent.
		tick_now = running && (count_tick || st.tick_pending) && !counter_read;
		edge_a_valid = edge_hit(input_a_edge, rise_a, fall_a);
		edge_b_valid = edge_hit(input_b_edge, rise_b, fall_b);
		if (st.reg_a_trigger_sel) begin
			trig_a = edge_opposite(input_a_edge, rise_a, fall_a);
		end else begin
			trig_a = edge_b_valid;
		end
		match_a = !st.reg_a_capture_sel && (st.up_counter == st.cc_reg_a);
		match_b = !st.reg_b_capture_sel && (st.up_counter == st.cc_reg_b);
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_st = st;
		next_st.irq_a = 1'b0;
		next_st.irq_b = 1'b0;
		next_st.tick_pending = running && counter_read && (count_tick || st.tick_pending);

		// Counter: cleared when stopped, on edge A in edge mode, on match A in match mode.
		if (!running) begin
			next_st.up_counter = COUNT_RESET;
		end else if (st.mode == TCC_CLEAR_ON_EDGE && edge_a_valid) begin
			next_st.up_counter = COUNT_RESET;
		end else if (tick_now) begin
			if (st.mode == TCC_CLEAR_ON_MATCH_A && match_a) begin
				next_st.up_counter = COUNT_RESET;
			end else begin
				// Wraps through zero, so a compare value below the count waits a lap.
				next_st.up_counter = st.up_counter + COUNT_STEP;
			end
		end

		// Matches use the count held during the tick, so 0000H fires after the wrap.
		if (tick_now) begin
			next_st.irq_a = match_a;
			next_st.irq_b = match_b;
			if ((st.mode == TCC_FREE_RUN || st.mode == TCC_CLEAR_ON_MATCH_A)
					&& (match_a || match_b)) begin
				next_st.tout = ~st.tout;
			end
		end

		// Register writes; byte access for control, whole words for the data registers.
		if (bus_wr) begin
			unique case (bus_addr)
				ADDR_TIMER_MODE_CONTROL: begin
					next_st.mode = tcc_mode_e'(bus_wdata[MODE_SEL_LO_POS +: 2]);
					next_st.overflow_flag = bus_wdata[OVERFLOW_FLAG_POS];
				end
				ADDR_CAPTURE_COMPARE_CONTROL: begin
					next_st.reg_a_capture_sel = bus_wdata[REG_A_CAPTURE_SEL_POS];
					next_st.reg_a_trigger_sel = bus_wdata[REG_A_TRIGGER_SEL_POS];
					next_st.reg_b_capture_sel = bus_wdata[REG_B_CAPTURE_SEL_POS];
				end
				ADDR_CC_REG_A: begin
					if (bus_word) begin
						next_st.cc_reg_a = bus_wdata;
					end
				end
				ADDR_CC_REG_B: begin
					if (bus_word) begin
						next_st.cc_reg_b = bus_wdata;
					end
				end
				default: begin
				end
			endcase
		end

		// Hardware set beats a software clear in the same cycle.
		if (tick_now && st.up_counter == COUNT_MAX) begin
			next_st.overflow_flag = 1'b1;
		end

		// Captures beat a simultaneous software write.
		if (running && st.reg_a_capture_sel && trig_a) begin
			next_st.cc_reg_a = st.up_counter;
		end
		if (running && st.reg_b_capture_sel && edge_a_valid) begin
			next_st.cc_reg_b = st.up_counter;
		end

		// Read data is registered; unmapped addresses read as zero.
		if (bus_rd) begin
			unique case (bus_addr)
				ADDR_TIMER_MODE_CONTROL:
					next_st.rdata = {12'h000, st.mode, 1'b0, st.overflow_flag};
				ADDR_CAPTURE_COMPARE_CONTROL:
					next_st.rdata = {13'h0000, st.reg_b_capture_sel, st.reg_a_trigger_sel,
						st.reg_a_capture_sel};
				ADDR_UP_COUNTER: next_st.rdata = st.up_counter;
				ADDR_CC_REG_A: next_st.rdata = st.cc_reg_a;
				ADDR_CC_REG_B: next_st.rdata = st.cc_reg_b;
				default: next_st.rdata = 16'h0000;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// The data registers keep no reset value; software loads them before use.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st.up_counter <= COUNT_RESET;
			st.mode <= TCC_STOP;
			st.overflow_flag <= TIMER_MODE_CONTROL_RESET[OVERFLOW_FLAG_POS];
			st.reg_b_capture_sel <= CAPTURE_COMPARE_CONTROL_RESET[REG_B_CAPTURE_SEL_POS];
			st.reg_a_trigger_sel <= CAPTURE_COMPARE_CONTROL_RESET[REG_A_TRIGGER_SEL_POS];
			st.reg_a_capture_sel <= CAPTURE_COMPARE_CONTROL_RESET[REG_A_CAPTURE_SEL_POS];
			st.tick_pending <= 1'b0;
			st.irq_a <= 1'b0;
			st.irq_b <= 1'b0;
			st.tout <= 1'b0;
			st.rdata <= 16'h0000;
			st.cc_reg_a <= st.cc_reg_a;
			st.cc_reg_b <= st.cc_reg_b;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign bus_rdata = st.rdata;
	assign match_irq_a = st.irq_a;
	assign match_irq_b = st.irq_b;
	assign timer_output = st.tout;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_STOP_CLEARS: assert property (ce && st.mode == TCC_STOP |=> st.up_counter == 16'h0000)
		else $error("Counter not cleared while stopped.");
	AST_STOP_QUIET: assert property (ce && st.mode == TCC_STOP
		|=> !match_irq_a && !match_irq_b && $stable(timer_output))
		else $error("Activity while stopped.");
	AST_MATCH_A_IRQ: assert property (ce && tick_now && !st.reg_a_capture_sel
		&& st.up_counter == st.cc_reg_a |=> match_irq_a)
		else $error("Missed match interrupt A.");
	AST_MATCH_B_IRQ: assert property (ce && tick_now && !st.reg_b_capture_sel
		&& st.up_counter == st.cc_reg_b |=> match_irq_b)
		else $error("Missed match interrupt B.");
	AST_CLEAR_ON_A: assert property (ce && st.mode == TCC_CLEAR_ON_MATCH_A && tick_now && match_a
		|=> st.up_counter == 16'h0000)
		else $error("Counter not cleared on match A.");
	AST_EDGE_CLEAR: assert property (ce && st.mode == TCC_CLEAR_ON_EDGE && edge_a_valid
		|=> st.up_counter == 16'h0000)
		else $error("Counter not cleared on edge A.");
	AST_FREE_STEP: assert property (ce && st.mode == TCC_FREE_RUN && tick_now
		|=> st.up_counter == $past(st.up_counter) + 16'h0001)
		else $error("Counter did not step.");
	AST_READ_HOLD: assert property (ce && running && counter_read && !bus_wr
		&& !(st.mode == TCC_CLEAR_ON_EDGE && edge_a_valid)
		|=> st.up_counter == $past(st.up_counter) ##0 st.tick_pending == $past(count_tick || st.tick_pending))
		else $error("Counter moved during read.");
	AST_OVF_SET: assert property (ce && tick_now && st.up_counter == 16'hFFFF |=> st.overflow_flag)
		else $error("Overflow flag not set.");
	AST_CAPTURE_B: assert property (ce && running && st.reg_b_capture_sel && edge_a_valid
		|=> st.cc_reg_b == $past(st.up_counter))
		else $error("Register B did not capture.");

	COV_IRQ_A: cover property (match_irq_a);
	COV_OVERFLOW: cover property ($rose(st.overflow_flag));
	COV_CAPTURE_A: cover property (ce && running && st.reg_a_capture_sel && trig_a);
	COV_READ_DEFER: cover property (ce && st.tick_pending);

endmodule

// ==== tb/tcc_pins.sv ====
// Model of the external trigger pins that feed the timer block.
`timescale 1ns/1ps
module tcc_pins (
	input wire logic clk,
	output logic edge_input_a,
	output logic edge_input_b
);
	// The shared pin only ever serves as an input here, so the output never drives it.
	initial begin
		edge_input_a = 1'b0;
		edge_input_b = 1'b0;
	end

	// Each new level is held six clocks, far beyond two count clock periods.
	task automatic drive(input logic sel_b, input logic lvl);
		@(negedge clk);
		if (sel_b) begin
			edge_input_b = lvl;
		end else begin
			edge_input_a = lvl;
		end
		repeat (6) @(negedge clk);
	endtask
endmodule

// ==== tb/tcc_core_tb.sv ====
// Self-checking testbench for the timer capture/compare block.
`timescale 1ns/1ps
module tcc_core_tb;
	import tcc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic count_tick = 1'b0;
	logic ce = 1'b1;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic bus_word = 1'b0;
	logic [7:0] prescaler_mode_reg = 8'h00;
	logic [15:0] bus_addr = 16'h0000;
	logic [15:0] bus_wdata = 16'h0000;
	logic [15:0] bus_rdata;
	logic [15:0] rd;
	logic match_irq_a;
	logic match_irq_b;
	logic timer_output;
	logic edge_input_a;
	logic edge_input_b;
	int fails = 0;
	int cmp_count = 0;
	int na = 0;
	int nb = 0;

	`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
		$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end

	tcc_core tcc_core_i (.clk(clk), .resetn(resetn), .ce(ce), .count_tick(count_tick),
		.prescaler_mode_reg(prescaler_mode_reg), .edge_input_a(edge_input_a),
		.edge_input_b(edge_input_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_word(bus_word), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .timer_output(timer_output));
	tcc_pins tcc_pins_i (.clk(clk), .edge_input_a(edge_input_a), .edge_input_b(edge_input_b));

	initial begin
		forever #25 clk = ~clk;
	end

	// Interrupts are single-cycle pulses, so they are counted rather than sampled.
	always @(posedge clk) begin
		if (match_irq_a === 1'b1) na++;
		if (match_irq_b === 1'b1) nb++;
	end

	// ************************************************************
	// Bus and stimulus tasks
	// ************************************************************
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_word = 1'b1;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask

	task automatic rdr(input logic [15:0] a);
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		rd = bus_rdata;
	endtask

	// Ticks are spaced one idle cycle apart; two idle cycles let the last pulse land.
	task automatic ticks(input int k);
		repeat (k) begin
			@(negedge clk);
			count_tick = 1'b1;
			@(negedge clk);
			count_tick = 1'b0;
		end
		repeat (2) @(negedge clk);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		rdr(ADDR_TIMER_MODE_CONTROL);
		`CHK(rd, 16'h0000)
		rdr(ADDR_CAPTURE_COMPARE_CONTROL);
		`CHK(rd, 16'h0000)
		rdr(16'hFF70);
		`CHK(rd, 16'h0000)
		$display("test reset done");
	endtask

	task automatic t_free;
		wr(ADDR_CC_REG_A, 16'h0002);
		wr(ADDR_CC_REG_B, 16'h0004);
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
		ticks(3);
		`CHK(na, 1)
		`CHK(timer_output, 1'b1)
		rdr(ADDR_UP_COUNTER);
		`CHK(rd, 16'h0003)
		// With the clock enable low the ticks must leave no trace.
		ce = 1'b0;
		ticks(2);
		ce = 1'b1;
		rdr(ADDR_UP_COUNTER);
		`CHK(rd, 16'h0003)
		ticks(2);
		`CHK(nb, 1)
		`CHK(timer_output, 1'b0)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
		ticks(3);
		rdr(ADDR_UP_COUNTER);
		`CHK(rd, 16'h0000)
		`CHK(na, 1)
		`CHK(timer_output, 1'b0)
		$display("test free run done");
	endtask

	task automatic t_clear_on_a;
		na = 0;
		wr(ADDR_CC_REG_A, 16'h0003);
		wr(ADDR_TIMER_MODE_CONTROL, 16'h000C);
		ticks(5);
		rdr(ADDR_UP_COUNTER);
		`CHK(rd, 16'h0001)
		`CHK(na, 1)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
		$display("test clear on match done");
	endtask

	task automatic t_capture;
		nb = 0;
		wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0004);
		prescaler_mode_reg = 8'h10;
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
		ticks(5);
		tcc_pins_i.drive(1'b0, 1'b1);
		rdr(ADDR_CC_REG_B);
		`CHK(rd, 16'h0005)
		`CHK(nb, 0)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
		prescaler_mode_reg = 8'h00;
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
		ticks(2);
		tcc_pins_i.drive(1'b0, 1'b0);
		rdr(ADDR_CC_REG_B);
		`CHK(rd, 16'h0002)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
		wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0001);
		prescaler_mode_reg = 8'h40;
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
		ticks(3);
		tcc_pins_i.drive(1'b1, 1'b1);
		rdr(ADDR_CC_REG_A);
		`CHK(rd, 16'h0003)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
		wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0003);
		prescaler_mode_reg = 8'h00;
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
		ticks(2);
		tcc_pins_i.drive(1'b0, 1'b1);
		rdr(ADDR_CC_REG_A);
		`CHK(rd, 16'h0002)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
		wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0000);
		tcc_pins_i.drive(1'b0, 1'b0);
		prescaler_mode_reg = 8'h10;
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0008);
		ticks(4);
		tcc_pins_i.drive(1'b0, 1'b1);
		rdr(ADDR_UP_COUNTER);
		`CHK(rd, 16'h0000)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0000);
		prescaler_mode_reg = 8'h00;
		$display("test capture done");
	endtask

	task automatic t_overflow;
		na = 0;
		nb = 0;
		wr(ADDR_CC_REG_A, 16'h0000);
		wr(ADDR_CC_REG_B, 16'h8000);
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
		@(negedge clk);
		count_tick = 1'b1;
		repeat (65537) @(negedge clk);
		count_tick = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(na, 2)
		`CHK(nb, 1)
		rdr(ADDR_TIMER_MODE_CONTROL);
		`CHK(rd, 16'h0005)
		wr(ADDR_TIMER_MODE_CONTROL, 16'h0004);
		rdr(ADDR_TIMER_MODE_CONTROL);
		`CHK(rd, 16'h0004)
		$display("test overflow done");
	endtask

	initial begin
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		t_reset();
		t_free();
		t_clear_on_a();
		t_capture();
		t_overflow();
		end_of_test();
	end

	initial begin
		#5000000;
		fails++;
		$display("unexpected at %0t: run did not finish", $time);
		end_of_test();
	end
endmodule
